/* hw/serial_flags_defines.vh */
// Constants for the serial status flag block: register map, field
// positions, reset values and bus response codes.
// Assumes inclusion by bare name from the design file.
`ifndef SERIAL_FLAGS_DEFINES_VH
`define SERIAL_FLAGS_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_FLAGS      5'h00
`define ADDR_CONTROL    5'h04
`define ADDR_MODE       5'h08
`define ADDR_TX_HOLD    5'h0c
`define ADDR_RX_HOLD    5'h10

// ****************************************
// serial_flags bit positions
// ****************************************
`define BIT_TX_EMPTY    7
`define BIT_RX_FULL     6
`define BIT_OVERRUN     5
`define BIT_FRAMING     4
`define BIT_PARITY      3
`define BIT_TX_DONE     2
`define BIT_RX_MP       1
`define BIT_TX_MP       0

// ****************************************
// Control and mode bit positions
// ****************************************
`define BIT_RX_ENABLE   0
`define BIT_TX_ENABLE   1
`define BIT_SYNC_MODE   0
`define BIT_PARITY_EN   1
`define BIT_PARITY_ODD  2
`define BIT_TWO_STOP    3
`define BIT_MP_FORMAT   4

// ****************************************
// Reset values and bus codes
// ****************************************
`define FLAGS_RESET     8'h84
`define CONTROL_RESET   2'h0
`define MODE_RESET      5'h00
`define BYTE_RESET      8'h00
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* hw/serial_status_flag_logic.v */
// Status flags, holding registers and AXI4-Lite access of a serial channel.
// Assumes a shifter on the same clock that reports character events as
// one-cycle pulses, and a dma controller on the same clock.
`include "serial_flags_defines.vh"

// Overview of operation
// RULE1: Clearing rx_enable keeps overrun_flag
// RULE2: Overrun keeps old byte, drops new
// RULE3: Overrun halts receive; sync also transmit
// RULE4: Async stop bit zero sets framing_flag
// RULE5: Only first stop bit is checked
// RULE6: Framing error loads byte, no rx_full
// RULE7: Framing error halts receive; sync also transmit
// RULE8: Framing flag cleared by read-one, write-zero
// RULE9: Reset or standby clears errors, sets tx_done
// RULE10: Clearing rx_enable keeps framing, parity flags
// RULE11: Parity mismatch sets parity_flag when enabled
// RULE12: Parity error loads byte, no rx_full
// RULE13: Parity error halts receive; sync also transmit
// RULE14: Parity flag cleared by read-one, write-zero
// RULE15: Last bit with tx_empty sets tx_done
// RULE16: Clearing tx_enable sets tx_done at once
// RULE17: tx_empty clear or dma write clears tx_done
// RULE18: tx_done bit is read-only; CPU writes to it are ignored
// RULE19: Async mp receive captures read-only rx_mp_bit
// RULE20: rx_enable clear keeps rx_mp_bit
// RULE21: Writable tx_mp_bit, reset zero, appended
// RULE22: tx_mp_bit unused outside async mp transmit
// RULE23: Completion while rx_full sets overrun
// RULE24: Flags ignore write one; clear after read
// RULE25: Zero write without prior read ignored
module serial_status_flag_logic (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        standby,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rx_char_done,
  input  wire [7:0]  rx_char_data,
  input  wire        rx_stop_bit,
  input  wire        rx_parity_bit,
  input  wire        rx_mp_in,
  input  wire        tx_load,
  input  wire        tx_last_bit,
  input  wire        dma_tx_write,
  input  wire [7:0]  dma_tx_data,
  input  wire        dma_rx_read,
  output wire        rx_run,
  output wire        tx_run,
  output wire        tx_char_valid,
  output reg  [7:0]  tx_char_data,
  output reg         tx_mp_out,
  output wire        sync_mode,
  output wire        parity_en,
  output wire        parity_odd,
  output wire        two_stop,
  output wire        mp_format
);

  // ****************************************
  // State
  // ****************************************
  reg        tx_empty_flag;
  reg        rx_full_flag;
  reg        overrun_flag;
  reg        framing_flag;
  reg        parity_flag;
  reg        tx_done_flag;
  reg        rx_mp_bit;
  reg        tx_mp_bit;
  reg [1:0]  serial_control_reg;
  reg [4:0]  serial_mode_reg;
  reg [7:0]  rx_holding_reg;
  reg [7:0]  tx_holding_reg;
  // Flags seen as one by a read; only these may be cleared by a write
  reg [7:3]  armed;

  reg        aw_held;
  reg [4:0]  aw_addr;
  reg        w_held;
  reg [7:0]  w_data;
  reg        w_lane;

  wire       rx_enable = serial_control_reg[`BIT_RX_ENABLE];
  wire       tx_enable = serial_control_reg[`BIT_TX_ENABLE];

  assign sync_mode  = serial_mode_reg[`BIT_SYNC_MODE];
  assign parity_en  = serial_mode_reg[`BIT_PARITY_EN];
  assign parity_odd = serial_mode_reg[`BIT_PARITY_ODD];
  assign two_stop   = serial_mode_reg[`BIT_TWO_STOP];
  assign mp_format  = serial_mode_reg[`BIT_MP_FORMAT];

  wire [7:0] flags_value = {tx_empty_flag, rx_full_flag, overrun_flag, framing_flag,
                            parity_flag, tx_done_flag, rx_mp_bit, tx_mp_bit};

  // ****************************************
  // Receive and transmit gating
  // ****************************************
  wire any_error = overrun_flag | framing_flag | parity_flag;

  assign rx_run        = rx_enable & ~any_error; // RULE3 RULE7 RULE13
  assign tx_run        = tx_enable & ~(sync_mode & any_error); // RULE3 RULE7 RULE13
  assign tx_char_valid = tx_run & ~tx_empty_flag;

  // Receive events and transmit loads count only while the matching side runs; the last bit needs only tx_enable
  wire rx_event   = rx_char_done & rx_run;
  wire tx_taken   = tx_load & tx_char_valid;
  wire tx_finish  = tx_last_bit & tx_enable;
  wire async_mode = ~sync_mode;

  // Shifter reports the first stop bit only; a second is never looked at
  wire stop_bad   = async_mode & ~rx_stop_bit; // RULE4 RULE5
  wire parity_bad = async_mode & parity_en &
                    ((^{rx_char_data, rx_parity_bit}) != parity_odd); // RULE11
  wire overrun_ev = rx_event & rx_full_flag; // RULE23
  wire framing_ev = rx_event & ~rx_full_flag & stop_bad;
  wire parity_ev  = rx_event & ~rx_full_flag & parity_bad;
  wire good_ev    = rx_event & ~rx_full_flag & ~stop_bad & ~parity_bad;
  // RULE2: byte is loaded only when the holding register is free
  wire load_rx    = rx_event & ~rx_full_flag; // RULE2 RULE6 RULE12

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

  wire do_write  = aw_held & w_held & ~s_axi_bvalid;
  wire wr_flags  = do_write & w_lane & (aw_addr == `ADDR_FLAGS);
  wire wr_ctrl   = do_write & w_lane & (aw_addr == `ADDR_CONTROL);
  wire wr_mode   = do_write & w_lane & (aw_addr == `ADDR_MODE);
  wire wr_tx     = do_write & w_lane & (aw_addr == `ADDR_TX_HOLD);
  wire wr_mapped = (aw_addr == `ADDR_FLAGS) | (aw_addr == `ADDR_CONTROL) |
                   (aw_addr == `ADDR_MODE) | (aw_addr == `ADDR_TX_HOLD) |
                   (aw_addr == `ADDR_RX_HOLD);

  // Clear only where a zero is written over a flag read as one
  wire [7:3] clr = {5{wr_flags}} & ~w_data[7:3] & armed; // RULE8 RULE14 RULE24 RULE25

  wire tx_empty_clr = clr[`BIT_TX_EMPTY];
  wire te_falling   = wr_ctrl & tx_enable & ~w_data[`BIT_TX_ENABLE];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      aw_addr      <= 5'h00;
      w_held       <= 1'b0;
      w_data       <= `BYTE_RESET;
      w_lane       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[4:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  assign s_axi_arready = ~s_axi_rvalid;

  wire       rd_take  = s_axi_arvalid & s_axi_arready;
  wire [4:0] rd_addr  = {s_axi_araddr[4:2], 2'b00};
  wire       rd_flags = rd_take & (rd_addr == `ADDR_FLAGS);

  reg [31:0] next_rdata;
  reg        next_rerr;

  always @* begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    case (rd_addr)
      `ADDR_FLAGS:   next_rdata[7:0] = flags_value;
      `ADDR_CONTROL: next_rdata[1:0] = serial_control_reg;
      `ADDR_MODE:    next_rdata[4:0] = serial_mode_reg;
      `ADDR_TX_HOLD: next_rdata[7:0] = tx_holding_reg;
      `ADDR_RX_HOLD: next_rdata[7:0] = rx_holding_reg;
      default:       next_rerr       = 1'b1;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Read-then-write-zero arming
  // ****************************************
  // A flags write with byte lane 0 enabled disarms unless a read arms the bit in the same cycle, so a later zero needs a fresh read
  genvar i;
  generate
    for (i = `BIT_PARITY; i <= `BIT_TX_EMPTY; i = i + 1) begin : arm_bits
      always @(posedge aclk) begin
        if (!aresetn || standby) begin
          armed[i] <= 1'b0;
        end else if (rd_flags && flags_value[i]) begin
          armed[i] <= 1'b1;
        end else if (wr_flags) begin
          armed[i] <= 1'b0; // RULE25
        end
      end
    end
  endgenerate

  // ****************************************
  // Control, mode and holding registers
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn || standby) begin
      serial_control_reg <= `CONTROL_RESET;
      serial_mode_reg    <= `MODE_RESET;
      tx_holding_reg     <= `BYTE_RESET;
      rx_holding_reg     <= `BYTE_RESET;
      tx_mp_bit          <= 1'b0; // RULE21
    end else begin
      if (wr_ctrl) begin
        serial_control_reg <= w_data[1:0];
      end
      if (wr_mode) begin
        serial_mode_reg <= w_data[4:0];
      end
      // Dma write wins a same-cycle collision with a cpu write
      if (dma_tx_write) begin
        tx_holding_reg <= dma_tx_data;
      end else if (wr_tx) begin
        tx_holding_reg <= w_data;
      end
      if (load_rx) begin
        rx_holding_reg <= rx_char_data;
      end
      if (wr_flags) begin
        tx_mp_bit <= w_data[`BIT_TX_MP]; // RULE21
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Hardware sets take priority over software clears in every flag
  always @(posedge aclk) begin
    if (!aresetn || standby) begin
      tx_empty_flag <= 1'b1; // RULE9
      rx_full_flag  <= 1'b0;
      overrun_flag  <= 1'b0;
      framing_flag  <= 1'b0; // RULE9
      parity_flag   <= 1'b0; // RULE9
      tx_done_flag  <= 1'b1; // RULE9
      rx_mp_bit     <= 1'b0;
    end else begin
      if (te_falling || tx_taken) begin
        tx_empty_flag <= 1'b1;
      end else if (tx_empty_clr || dma_tx_write) begin
        tx_empty_flag <= 1'b0;
      end

      if (good_ev) begin
        rx_full_flag <= 1'b1;
      end else if (clr[`BIT_RX_FULL] || dma_rx_read) begin
        rx_full_flag <= 1'b0;
      end

      // Clearing rx_enable has no path into these three
      if (overrun_ev) begin
        overrun_flag <= 1'b1; // RULE1 RULE23
      end else if (clr[`BIT_OVERRUN]) begin
        overrun_flag <= 1'b0; // RULE24
      end

      if (framing_ev) begin
        framing_flag <= 1'b1; // RULE4 RULE10
      end else if (clr[`BIT_FRAMING]) begin
        framing_flag <= 1'b0; // RULE8
      end

      if (parity_ev) begin
        parity_flag <= 1'b1; // RULE11 RULE10
      end else if (clr[`BIT_PARITY]) begin
        parity_flag <= 1'b0; // RULE14
      end

      // Flags write data never reaches it; control and tx_empty writes still set or clear it
      if (te_falling) begin
        tx_done_flag <= 1'b1; // RULE16 RULE18
      end else if (tx_finish && tx_empty_flag) begin
        tx_done_flag <= 1'b1; // RULE15
      end else if (tx_empty_clr || dma_tx_write) begin
        tx_done_flag <= 1'b0; // RULE17
      end

      // Captured only from accepted characters; stays put when receive stops
      if (load_rx && async_mode && mp_format) begin
        rx_mp_bit <= rx_mp_in; // RULE19 RULE20
      end
    end
  end

  // ****************************************
  // Data toward the shifter
  // ****************************************
  // Sampled into the output byte so the shifter sees a stable character
  always @(posedge aclk) begin
    if (!aresetn || standby) begin
      tx_char_data <= `BYTE_RESET;
      tx_mp_out    <= 1'b0;
    end else begin
      tx_char_data <= tx_holding_reg;
      tx_mp_out    <= tx_mp_bit & async_mode & mp_format & tx_enable; // RULE21 RULE22
    end
  end

endmodule

/* dv/serial_flags_chk.sv */
// Port assertions for the serial status flag block.
// Assumes a bind to the block's top ports, one clock domain.
module serial_flags_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        rx_char_done,
  input wire [7:0]  rx_char_data,
  input wire        rx_stop_bit,
  input wire        rx_parity_bit,
  input wire        tx_load,
  input wire        rx_run,
  input wire        tx_run,
  input wire        tx_char_valid,
  input wire        tx_mp_out,
  input wire        sync_mode,
  input wire        parity_en,
  input wire        parity_odd,
  input wire        mp_format
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence rx_taken;
    rx_char_done && rx_run && !sync_mode;
  endsequence
  sequence w_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer not held");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  // Response follows one cycle after both channels are held
  write_answer_a: assert property (w_both |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write answer late");
  framing_halt_a: assert property (
    rx_taken ##0 !rx_stop_bit |=> !rx_run)
    else $error("receive not halted on bad stop bit");
  parity_halt_a: assert property (
    rx_taken ##0 (parity_en && (^{rx_char_data, rx_parity_bit}) != parity_odd)
    |=> !rx_run)
    else $error("receive not halted on bad parity");
  tx_valid_a: assert property (tx_char_valid && tx_load |=> !tx_char_valid)
    else $error("transmit byte offered again after load");
  tx_idle_mp_a: assert property (!tx_run |=> !tx_mp_out)
    else $error("mp bit sent while not transmitting");
  mp_gate_a: assert property (sync_mode || !mp_format |=> !tx_mp_out)
    else $error("mp bit sent outside mp format");
endmodule

/* dv/serial_peer.sv */
// Remote station: sends characters, drains the transmit shifter.
// Assumes the block's clock and one-cycle event pulses.
module serial_peer (
  input  wire        aclk,
  input  wire        tx_char_valid,
  output logic       rx_char_done,
  output logic [7:0] rx_char_data,
  output logic       rx_stop_bit,
  output logic       rx_parity_bit,
  output logic       rx_mp_in,
  output logic       tx_load,
  output logic       tx_last_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic v;
  int   c = 0;
  initial {rx_char_done, rx_char_data, rx_stop_bit, rx_parity_bit, rx_mp_in,
           tx_load, tx_last_bit} = 14'h0;
  // Lines go to inverse after a character so stale values never pass
  task automatic send(input logic [7:0] d, input logic s, p, m);
    @(posedge aclk);
    {rx_char_done, rx_char_data, rx_stop_bit, rx_parity_bit, rx_mp_in} <= {1'h1, d, s, p, m};
    @(posedge aclk);
    {rx_char_done, rx_char_data, rx_stop_bit, rx_parity_bit, rx_mp_in} <= {1'h0, ~d, ~s, ~p, ~m};
  endtask
  // Sampled mid-cycle to stay clear of the edge
  always @(negedge aclk) v = tx_char_valid;
  // Slow shifter: last bit leaves 30 cycles after the load
  always @(posedge aclk) begin
    tx_load <= v && c == 0;
    tx_last_bit <= c == 1;
    if (v && c == 0)
      c <= 30;
    else if (c > 0)
      c <= c - 1;
  end
endmodule

/* dv/tb_top.sv */
// Testbench: registers over AXI4-Lite, remote station on the line side.
// Assumes the design header is on the include path.
`include "serial_flags_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        standby = 1'h0;
  logic [4:0]  s_axi_awaddr = 5'h0;
  logic [4:0]  s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        dma_tx_write = 1'h0;
  logic        dma_rx_read = 1'h0;
  logic [7:0]  dma_tx_data = 8'h0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         rx_char_done, rx_stop_bit, rx_parity_bit, rx_mp_in, tx_load, tx_last_bit;
  wire  [7:0]  rx_char_data, tx_char_data;
  wire         rx_run, tx_run, tx_char_valid, tx_mp_out;
  wire         sync_mode, parity_en, parity_odd, two_stop, mp_format;
  logic [31:0] rv;
  logic [1:0]  rr;
  int          err_count = 0;
  int          comparisons = 0;

  always #20 aclk = ~aclk;
  serial_status_flag_logic u_dut (.*);
  serial_peer u_peer (.*);

  // ****
  // Bus and check tasks
  // ****
  task automatic print_verdict;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic timeout;
    chk("wait", 1, 0);
    print_verdict();
  endtask
  // Ready is sampled mid-cycle, payload moves only after the edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic aw, w, b;
    b = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; !b; n++) begin
      if (n == 40) timeout();
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [4:0] a);
    logic ar, b;
    b = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; !b; n++) begin
      if (n == 40) timeout();
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      b = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask
  task automatic fl(input logic [7:0] e);
    rd(`ADDR_FLAGS);
    chk("flags", e, rv);
  endtask
  task automatic wt(input logic last);
    for (int n = 0; n <= 100; n++) begin
      if (n == 100) timeout();
      @(negedge aclk);
      if (last ? tx_last_bit : tx_load) break;
    end
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    fl(`FLAGS_RESET);
    rd(5'h14);
    chk("unmapped", `RESP_SLVERR, rr);
    wr(5'h14, 8'h00);
    chk("unmapped write", `RESP_SLVERR, rr);
    wr(`ADDR_FLAGS, 8'h80);
    fl(`FLAGS_RESET);
    wr(`ADDR_FLAGS, 8'hff);
    chk("bresp", `RESP_OKAY, rr);
    fl(8'h85);
    @(posedge aclk);
    standby <= 1'h1;
    @(posedge aclk);
    standby <= 1'h0;
    fl(`FLAGS_RESET);
    // Write with lane 0 masked must leave the mode register alone
    s_axi_wstrb <= 4'h0;
    wr(`ADDR_MODE, 8'h1f);
    s_axi_wstrb <= 4'hf;
    rd(`ADDR_MODE);
    chk("masked write", 32'h0, rv);
    $display("test reset done");
  endtask
  task automatic t_frame;
    wr(`ADDR_CONTROL, 8'h01);
    rd(`ADDR_FLAGS);
    u_peer.send(8'h5a, 1'h0, 1'h0, 1'h0);
    wr(`ADDR_FLAGS, 8'h84);
    fl(8'h94);
    rd(`ADDR_RX_HOLD);
    chk("rx hold", 8'h5a, rv);
    u_peer.send(8'h11, 1'h1, 1'h0, 1'h0);
    rd(`ADDR_RX_HOLD);
    chk("rx hold", 8'h5a, rv);
    wr(`ADDR_CONTROL, 8'h00);
    fl(8'h94);
    wr(`ADDR_FLAGS, 8'h84);
    fl(8'h84);
    $display("test framing done");
  endtask
  task automatic t_parity;
    wr(`ADDR_MODE, 8'h06);
    wr(`ADDR_CONTROL, 8'h01);
    u_peer.send(8'h01, 1'h1, 1'h1, 1'h0);
    fl(8'h8c);
    rd(`ADDR_RX_HOLD);
    chk("rx hold", 8'h01, rv);
    fl(8'h8c);
    wr(`ADDR_FLAGS, 8'h84);
    fl(8'h84);
    wr(`ADDR_MODE, 8'h0a);
    chk("two stop", 1'h1, two_stop);
    u_peer.send(8'h03, 1'h1, 1'h0, 1'h0);
    fl(8'hc4);
    $display("test parity done");
  endtask
  task automatic t_over;
    wr(`ADDR_MODE, 8'h01);
    chk("sync mode", 1'h1, sync_mode);
    wr(`ADDR_CONTROL, 8'h03);
    u_peer.send(8'h77, 1'h1, 1'h0, 1'h0);
    fl(8'he4);
    rd(`ADDR_RX_HOLD);
    chk("rx hold", 8'h03, rv);
    chk("tx run", 1'h0, tx_run);
    wr(`ADDR_CONTROL, 8'h00);
    fl(8'he4);
    wr(`ADDR_FLAGS, 8'h84);
    fl(8'h84);
    $display("test overrun done");
  endtask
  task automatic t_tx;
    wr(`ADDR_MODE, 8'h10);
    wr(`ADDR_CONTROL, 8'h02);
    @(posedge aclk);
    {dma_tx_write, dma_tx_data} <= {1'h1, 8'h3c};
    @(posedge aclk);
    dma_tx_write <= 1'h0;
    wt(1'h0);
    chk("tx data", 8'h3c, tx_char_data);
    chk("tx mp", 1'h0, tx_mp_out);
    fl(8'h80);
    wt(1'h1);
    fl(8'h84);
    wr(`ADDR_FLAGS, 8'h85);
    wr(`ADDR_TX_HOLD, 8'ha5);
    fl(8'h85);
    wr(`ADDR_FLAGS, 8'h05);
    wt(1'h0);
    chk("tx data", 8'ha5, tx_char_data);
    chk("tx mp", 1'h1, tx_mp_out);
    fl(8'h81);
    wr(`ADDR_CONTROL, 8'h00);
    fl(8'h85);
    $display("test transmit done");
  endtask
  task automatic t_mp;
    wr(`ADDR_CONTROL, 8'h01);
    u_peer.send(8'h42, 1'h1, 1'h0, 1'h1);
    fl(8'hc7);
    @(posedge aclk);
    dma_rx_read <= 1'h1;
    @(posedge aclk);
    dma_rx_read <= 1'h0;
    wr(`ADDR_CONTROL, 8'h00);
    fl(8'h87);
    $display("test mp receive done");
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_frame();
    t_parity();
    t_over();
    t_tx();
    t_mp();
    print_verdict();
  end
endmodule

bind serial_status_flag_logic serial_flags_chk u_chk (.*);
